// [hdl/drc_pkg.sv]
// Package: constants, types and commands for the drum range comparator
package drc_pkg;
	localparam int DRC_WORD_W = 16;
	localparam int DRC_DRUM_MAX = 9999;
	localparam logic [15:0] DRC_DRUM_MAX_BCD = 16'h9999;
	localparam logic [8:0] DRC_SLOT_LO = 9'd500;
	localparam logic [8:0] DRC_SLOT_HI = 9'd511;
	localparam logic [8:0] DRC_FAST_SLOT = 9'd511;
	localparam int DRC_COUNT_LSB = 0;
	localparam int DRC_COUNT_MSB = 7;
	localparam int DRC_BLOCK_RANGES = 16;
	localparam logic [15:0] DRC_PV_RESET = 16'h0000;

	// Operation requested for one evaluation
	typedef enum logic [1:0] {
		DRC_OP_DRUM,
		DRC_OP_FAST,
		DRC_OP_BLOCK
	} drc_op_t;

	// Table memory read request
	typedef struct packed {
		logic req;
		logic [9:0] addr;
	} drc_mem_req_t;

	// Counter step command for the drum counter
	typedef struct packed {
		logic step;
		logic down;
		logic clear;
	} drc_step_t;
endpackage

// [hdl/drc_range_compare.sv]
// Drum counter, fast drum and block range comparison engine
// What this block does
// - Drum count wraps 0 to 9999 both ways
// - Every containing range up to MAX_RANGES turns its result bit
// - Entry count from first word bits 00..07
// - Fast variant compares fast counter value
// - Block compare: 16-bit binary, 16 ranges
//
// Interface notes
// Clock: single domain, rising edge only
// Reset: asynchronous, active low, all outputs cleared
// Step command: sampled every edge, clear beats step
// Count register: BCD, four digits, wraps both ways
// Start: taken only while idle, one-cycle pulse
// Start while busy: ignored, no queueing
// Op, table base, block key: taken with start
// Key latched at start, later input moves harmless
// Drum pass: head word first, then low/high pairs
// Block pass: sixteen pairs straight from the base
// Pair layout: low word first, high word next
// Bounds inclusive at both ends
// Head count zero: empty pass, all bits clear
// Head count above result width: clipped, not wrapped
// Memory request: registered, one word per answer
// Request held until the answer strobe arrives
// Answer strobe must only follow a live request
// Extra strobes would be taken as the next word
// Done: one-cycle pulse, result updates with it
// Result: stands unchanged until the next done
// Busy: high from start until the done cycle
// Compare is plain unsigned magnitude
// BCD ordered like hex, so one comparator serves
// Block key is binary; same comparator applies
// Slot and area placement left to the caller
// Table words assumed BCD, never checked here
// Limitation: one pass at a time, no overlap
// Trade-off: serial compare, one pair per two answers
// Saves comparators, costs two answers per range
// Pass length grows with entries and answer delay
`timescale 1ns/1ns
`default_nettype none
module drc_range_compare
	import drc_pkg::*;
#(
	parameter int MAX_RANGES = 16,
	parameter int ADDR_W = 10
) (
	input wire logic clock,
	input wire logic resetn,
	input wire drc_step_t step_cmd,
	input wire logic [15:0] fast_count_value,
	input wire logic start,
	input wire drc_op_t op,
	input wire logic [ADDR_W-1:0] compare_table_base,
	input wire logic [15:0] block_input,
	output var drc_mem_req_t mem_req,
	input wire logic [15:0] mem_rdata,
	input wire logic mem_rvalid,
	output logic busy,
	output logic done,
	output logic [MAX_RANGES-1:0] result,
	output logic [15:0] present_count_value
);
	typedef enum logic [2:0] {S_IDLE, S_HEAD, S_LOW, S_HIGH, S_DONE} drc_state_t;

	// Elaboration check: at most 256 result bits, block needs sixteen, ADDR_W must be 10
	if (MAX_RANGES < DRC_BLOCK_RANGES || MAX_RANGES > 256 || ADDR_W != 10) begin : g_bad_params
		$error("drc_range_compare: unsupported parameters");
	end

	drc_state_t state;
	drc_op_t cur_op;
	logic [ADDR_W-1:0] rd_addr;
	logic [8:0] entries;
	logic [8:0] index;
	logic [15:0] key;
	logic [15:0] low_limit;
	logic [MAX_RANGES-1:0] acc;
	logic [15:0] next_pv;
	logic range_hit;
	logic [MAX_RANGES-1:0] hit_vec;

	// Inclusive containment of the key in the current pair
	always_comb range_hit = (key >= low_limit) && (key <= mem_rdata);

	// One decode per result bit; only the entry under compare can light
	for (genvar gi = 0; gi < MAX_RANGES; gi++) begin : g_hit
		assign hit_vec[gi] = range_hit && (index == 9'(gi));
	end

	// BCD increment/decrement with wrap at 9999 and 0
	function automatic logic [15:0] bcd_step(input logic [15:0] v, input logic down);
		logic [15:0] r;
		logic carry;
		r = v;
		carry = 1'b1;
		for (int d = 0; d < 4; d++) begin
			if (carry) begin
				if (!down) begin
					carry = (v[d*4 +: 4] == 4'h9);
					r[d*4 +: 4] = carry ? 4'h0 : v[d*4 +: 4] + 4'h1;
				end else begin
					carry = (v[d*4 +: 4] == 4'h0);
					r[d*4 +: 4] = carry ? 4'h9 : v[d*4 +: 4] - 4'h1;
				end
			end
		end
		return r;
	endfunction

	// Next drum value; wrap falls out of the digit carry chain
	always_comb begin
		next_pv = present_count_value;
		if (step_cmd.clear)
			next_pv = DRC_PV_RESET;
		else if (step_cmd.step)
			next_pv = bcd_step(present_count_value, step_cmd.down);
	end

	// Drum counter register, held in BCD like its table entries
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			present_count_value <= DRC_PV_RESET;
		else
			present_count_value <= next_pv;
	end

	// Sequencer: one table word per memory answer
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state <= S_IDLE;
			cur_op <= DRC_OP_DRUM;
			rd_addr <= '0;
			entries <= '0;
			index <= '0;
			key <= '0;
			low_limit <= '0;
			acc <= '0;
		end else begin
			unique case (state)
				S_IDLE: begin
					if (start) begin
						cur_op <= op;
						acc <= '0;
						index <= '0;
						rd_addr <= compare_table_base;
						// Key latched at start so a moving count cannot tear the pass
						unique case (op)
							DRC_OP_DRUM: key <= present_count_value;
							DRC_OP_FAST: key <= fast_count_value;
							default: key <= block_input;
						endcase
						if (op == DRC_OP_BLOCK) begin
							entries <= 9'(DRC_BLOCK_RANGES);
							state <= S_LOW;
						end else begin
							state <= S_HEAD;
						end
					end
				end
				S_HEAD: begin
					if (mem_rvalid) begin
						// Counts above MAX_RANGES are clipped to the result width
						entries <= (9'(mem_rdata[DRC_COUNT_MSB:DRC_COUNT_LSB]) > 9'(MAX_RANGES)) ?
							9'(MAX_RANGES) : 9'(mem_rdata[DRC_COUNT_MSB:DRC_COUNT_LSB]);
						rd_addr <= rd_addr + 10'd1;
						state <= (mem_rdata[DRC_COUNT_MSB:DRC_COUNT_LSB] == 8'h00) ? S_DONE : S_LOW;
					end
				end
				S_LOW: begin
					if (mem_rvalid) begin
						low_limit <= mem_rdata;
						rd_addr <= rd_addr + 10'd1;
						state <= S_HIGH;
					end
				end
				S_HIGH: begin
					if (mem_rvalid) begin
						// Plain compare is valid for BCD too: digit order preserves magnitude
						acc <= acc | hit_vec;
						rd_addr <= rd_addr + 10'd1;
						index <= index + 9'd1;
						state <= (index + 9'd1 >= entries) ? S_DONE : S_LOW;
					end
				end
				S_DONE: begin
					state <= S_IDLE;
				end
				default: state <= S_IDLE;
			endcase
		end
	end

	// Memory request, registered
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			mem_req <= '0;
		end else begin
			mem_req.req <= (state == S_HEAD || state == S_LOW || state == S_HIGH) && !mem_rvalid;
			mem_req.addr <= rd_addr;
		end
	end

	// Status and result; result updates whole so bits never glitch mid-pass
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			busy <= 1'b0;
			done <= 1'b0;
			result <= '0;
		end else begin
			busy <= (state != S_IDLE && state != S_DONE) || (state == S_IDLE && start);
			done <= (state == S_DONE);
			if (state == S_DONE)
				result <= acc;
		end
	end
endmodule
`default_nettype wire

// [test/drc_range_compare_chk.sv]
// Port assertions for the drum range comparator
`timescale 1ns/1ns
`default_nettype none
module drc_chk
	import drc_pkg::*;
#(parameter int MAX_RANGES = 16) (
	input wire logic clock,
	input wire logic resetn,
	input wire drc_step_t step_cmd,
	input wire logic start,
	input wire drc_mem_req_t mem_req,
	input wire logic mem_rvalid,
	input wire logic busy,
	input wire logic done,
	input wire logic [MAX_RANGES-1:0] result,
	input wire logic [15:0] present_count_value
);
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	// Start taken only while idle
	sequence go_s;
		start && !busy;
	endsequence
	wrap_up_a: assert property (step_cmd == 3'b100 && present_count_value == DRC_DRUM_MAX_BCD
		|-> ##[1:2] present_count_value == 16'h0000) else $error("bad up wrap");
	wrap_dn_a: assert property (step_cmd == 3'b110 && present_count_value == 16'h0000
		|-> ##[1:2] present_count_value == DRC_DRUM_MAX_BCD) else $error("bad down wrap");
	eval_end_a: assert property (go_s |-> ##[3:1000] done) else $error("no done");
	done_pulse_a: assert property (done |-> !busy ##1 !done) else $error("long done");
	res_hold_a: assert property ($changed(result) |-> done) else $error("result moved");
	req_hold_a: assert property (mem_req.req && !mem_rvalid |=> $stable(mem_req)) else $error("req moved");
endmodule
bind drc_range_compare drc_chk #(.MAX_RANGES(MAX_RANGES)) chk (.*);
`default_nettype wire

// [test/tb_top.sv]
// Bench for the drum range comparator
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import drc_pkg::*;
	logic clock = 0, resetn = 0, start = 0, mem_rvalid = 0, busy, done, g;
	drc_step_t step_cmd = '0;
	drc_op_t op = DRC_OP_DRUM;
	logic [9:0] compare_table_base = '0;
	logic [15:0] fast_count_value = '0, block_input = '0, mem_rdata = '0, present_count_value, result, e;
	drc_mem_req_t mem_req;
	logic [15:0] mem [1024];
	int failures = 0, n_tests = 0;
	drc_range_compare uut (.*);
	// Clock
	always #4 clock = ~clock;
	// Memory answers late at random, inverted junk data on every held-back cycle
	always @(posedge clock) begin
		g = $urandom_range(1);
		mem_rvalid <= mem_req.req && !mem_rvalid && g;
		mem_rdata <= g ? mem[mem_req.addr] : ~mem[mem_req.addr];
	end
	task chk(string s, logic [15:0] x, logic [15:0] v);
		n_tests++;
		if (x !== v) begin
			failures++;
			$display("wrong value %s expected %h seen %h", s, x, v);
		end
	endtask
	// One counter command held for one edge
	task stp(drc_step_t c, logic [15:0] x);
		@(posedge clock);
		step_cmd <= c;
		@(posedge clock);
		step_cmd <= '0;
		repeat (2) @(posedge clock);
		chk("count", x, present_count_value);
	endtask
	// One evaluation; model uses inclusive pairs, clipped count
	task run(drc_op_t o, int b, logic [15:0] k);
		@(posedge clock);
		op <= o;
		compare_table_base <= b[9:0];
		block_input <= k;
		fast_count_value <= k;
		start <= 1;
		@(posedge clock);
		start <= 0;
		@(posedge clock);
		chk("busy", 16'h0001, {15'h0000, busy});
		e = '0;
		b += o != DRC_OP_BLOCK;
		for (int i = 0; i < (o == DRC_OP_BLOCK ? 16 : mem[b - 1][7:0]) && i < 16; i++)
			e[i] = k >= mem[b + 2 * i] && k <= mem[b + 2 * i + 1];
		repeat (2000) if (done !== 1'b1) @(posedge clock);
		chk("done", 16'h0001, {15'h0000, done});
		chk("result", e, result);
	endtask
	task print_verdict;
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Main sequence
	initial begin
		void'($urandom(29));
		// Drum slot is the caller's, no slot input exists
		foreach (mem[i]) mem[i] = $urandom & 16'h9999;
		mem[0] = 16'h0005;
		mem[60] = 16'h0000;
		mem[1] = 16'h0000;
		mem[40] = 16'h00FF;
		repeat (3) @(posedge clock);
		resetn <= 1;
		stp(3'b110, 16'h9999);
		stp(3'b100, 16'h0000);
		stp(3'b100, 16'h0001);
		run(DRC_OP_DRUM, 0, 16'h0001);
		run(DRC_OP_DRUM, 40, 16'h0001);
		run(DRC_OP_FAST, 0, $urandom);
		run(DRC_OP_DRUM, 60, 16'h0001);
		run(DRC_OP_BLOCK, 300, mem[300]);
		stp(3'b101, 16'h0000);
		print_verdict;
	end
	// Watchdog against a hung evaluation
	initial begin
		#100000;
		failures++;
		print_verdict;
	end
endmodule
`default_nettype wire
